// File: logic/cpmsl_ctrl.sv
/*
 * Direct-control and supply-mode logic of an eight-channel driver:
 * input mapping, channel OR, mode selection, supply gating.
 * Assumes the serial engine writes registers through the write port and
 * that undervoltage flags arrive from analog comparators on pins.
 */
// Summary of operation
// - After reset input a drives channel 2, input b channel 3.
// - Two mapping registers let each input drive other channel sets.
// - Channel drive is OR of output register, PWM map, input map.
// - Input level monitor shows present level of each input pin.
// - Input level monitor keeps tracking while in limp-home mode.
// - Sleep pin low and any input high: limp-home, default mapping.
// - Sleep pin low and both inputs low: sleep mode.
// - While sleep pin low, serial registers held at defaults.
// - Sleep mode disables both undervoltage detectors.
// - Sleep mode refuses serial access, serial output stays off.
// - Both supplies undervoltage: no channels, no serial, registers reset.
// - Digital undervoltage: serial blocked, registers back to defaults.
// - Analog undervoltage disables channels; re-enable at operating level.
// - Between thresholds, channels already on keep their state.
// - Between thresholds, switching on an off channel is refused.
// - Analog supply at or below 3.0 V: no channel control.
`timescale 1ns/1ps
`default_nettype none
module cpmsl_ctrl
   import cpmsl_pkg::*;
#(
   parameter int CH = CPMSL_CHANNELS
) (
   input  wire logic          i_clk,
   input  wire logic          i_rst,
   input  wire logic          i_ce,
   input  wire logic          i_direct_input_a,
   input  wire logic          i_direct_input_b,
   input  wire logic          i_sleep_req_n,
   input  wire logic          i_chip_select_n,
   input  wire logic          i_spi_so_data,
   input  wire logic          i_vdd_uv,
   input  wire logic          i_vs_uv,
   input  wire logic          i_vs_below_op,
   input  wire logic [1:0]    i_pwm,
   input  wire logic          i_wr_en,
   input  wire logic [1:0]    i_wr_sel,
   input  wire logic [CH-1:0] i_wr_data,
   output logic      [CH-1:0] o_channel_drive,
   output logic      [1:0]    o_input_level_monitor,
   output logic      [CH-1:0] o_input_a_channel_map,
   output logic      [CH-1:0] o_input_b_channel_map,
   output logic      [CH-1:0] o_out_reg,
   output logic      [1:0]    o_mode,
   output logic               o_serial_enable,
   output logic               o_uv_detect_enable,
   output logic               o_so_out,
   output logic               o_so_oe_n
);
   // Default masks and mode tables are sized for eight channels only
   if (CH != 8) begin : g_bad_ch
      $error("cpmsl_ctrl: only eight channels supported");
   end


   localparam logic [1:0] SEL_OUT  = 2'h0;
   localparam logic [1:0] SEL_MAPA = 2'h1;
   localparam logic [1:0] SEL_MAPB = 2'h2;
   localparam logic [1:0] SEL_PWMM = 2'h3;

   logic [3:0]     pins_s;
   logic           in_a;
   logic           in_b;
   logic           sleep_n;
   logic           vdd_uv;
   logic           vs_uv;
   logic           vs_low;
   logic [CH-1:0]  map_a_reg;
   logic [CH-1:0]  map_b_reg;
   logic [CH-1:0]  out_reg;
   logic [CH-1:0]  pwm_map_reg;
   logic [CH-1:0]  drive_reg;
   logic [CH-1:0]  drive_next;
   logic [CH-1:0]  req;
   logic [1:0]     mon_reg;
   cpmsl_mode_t    mode_reg;
   cpmsl_mode_t    mode_next;
   logic           regs_hold;
   logic           serial_ok;
   logic           any_in;

   cpmsl_sync2 #(.W(4)) u_sync (
      .i_clk     (i_clk),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_async   ({i_direct_input_a, i_direct_input_b, i_sleep_req_n,
                   i_chip_select_n}),
      .i_rst_val (4'h3),
      .o_sync    (pins_s)
   );

   // Supply flags also cross; a separate pair keeps the pin pair compact
   logic [2:0] uv_s;
   cpmsl_sync2 #(.W(3)) u_sync_uv (
      .i_clk     (i_clk),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_async   ({i_vdd_uv, i_vs_uv, i_vs_below_op}),
      .i_rst_val (3'h0),
      .o_sync    (uv_s)
   );

   assign in_a    = pins_s[3];
   assign in_b    = pins_s[2];
   assign sleep_n = pins_s[1];
   assign any_in  = in_a | in_b;

   // Detectors are off in sleep, so their flags are ignored there
   assign vdd_uv  = uv_s[2] & o_uv_detect_enable;
   assign vs_uv   = uv_s[1] & o_uv_detect_enable;
   assign vs_low  = (uv_s[0] | uv_s[1]) & o_uv_detect_enable;

   always_comb begin
      if (sleep_n)
         mode_next = CPMSL_MODE_NORMAL;
      else if (any_in)
         mode_next = CPMSL_MODE_LIMP;
      else
         mode_next = CPMSL_MODE_SLEEP;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst)
         mode_reg <= CPMSL_MODE_NORMAL;
      else if (i_ce)
         mode_reg <= mode_next;
   end

   // Register file held at defaults by sleep pin or digital undervoltage
   assign regs_hold = ~sleep_n | vdd_uv;
   assign serial_ok = (mode_reg == CPMSL_MODE_NORMAL) & ~vdd_uv;

   always_ff @(posedge i_clk) begin
      if (i_rst || (i_ce && regs_hold)) begin
         map_a_reg   <= CPMSL_MAP_A_DEFAULT;
         map_b_reg   <= CPMSL_MAP_B_DEFAULT;
         out_reg     <= CPMSL_OUT_DEFAULT;
         pwm_map_reg <= CPMSL_PWM_MAP_DEFAULT;
      end else if (i_ce && i_wr_en && serial_ok) begin
         unique case (i_wr_sel)
            SEL_OUT:  out_reg     <= i_wr_data;
            SEL_MAPA: map_a_reg   <= i_wr_data;
            SEL_MAPB: map_b_reg   <= i_wr_data;
            SEL_PWMM: pwm_map_reg <= i_wr_data;
         endcase
      end
   end

   // Monitor follows pins in every mode, limp-home included
   always_ff @(posedge i_clk) begin
      if (i_rst)
         mon_reg <= 2'h0;
      else if (i_ce)
         mon_reg <= {in_b, in_a};
   end

   always_comb begin
      if (mode_reg == CPMSL_MODE_LIMP)
         req = ({CH{in_a}} & CPMSL_MAP_A_DEFAULT)
             | ({CH{in_b}} & CPMSL_MAP_B_DEFAULT);
      else
         req = out_reg | ({CH{|i_pwm}} & pwm_map_reg)
             | ({CH{in_a}} & map_a_reg)
             | ({CH{in_b}} & map_b_reg);
      if (vs_uv || (vdd_uv && vs_uv))
         drive_next = '0;
      else if (vs_low)
         drive_next = req & drive_reg;
      else
         drive_next = req;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst)
         drive_reg <= '0;
      else if (i_ce)
         drive_reg <= drive_next;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst)
         o_so_out <= 1'b0;
      else if (i_ce)
         o_so_out <= i_spi_so_data;
   end

   assign o_channel_drive       = drive_reg;
   assign o_input_level_monitor = mon_reg;
   assign o_input_a_channel_map = map_a_reg;
   assign o_input_b_channel_map = map_b_reg;
   assign o_out_reg             = out_reg;
   assign o_mode                = mode_reg;
   assign o_serial_enable       = serial_ok;
   assign o_uv_detect_enable    = (mode_reg != CPMSL_MODE_SLEEP);
   // Serial output released unless selected and serial access allowed
   assign o_so_oe_n = ~(serial_ok & ~pins_s[0]);

   // Steps shared by the mode and supply checks
   sequence seq_limp_req;
      i_ce && !sleep_n && any_in;
   endsequence : seq_limp_req

   sequence seq_sleep_req;
      i_ce && !sleep_n && !any_in;
   endsequence : seq_sleep_req

   sequence seq_both_uv;
      i_ce && vdd_uv && vs_uv;
   endsequence : seq_both_uv

   sequence seq_normal_full;
      i_ce && (mode_reg == CPMSL_MODE_NORMAL) && !vs_low;
   endsequence : seq_normal_full

   AST_SLEEP_NO_SO: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (mode_reg == CPMSL_MODE_SLEEP) |-> o_so_oe_n)
      else $error("serial output driven in sleep");
   AST_SLEEP_NO_UV: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (mode_reg == CPMSL_MODE_SLEEP) |-> !o_uv_detect_enable)
      else $error("uv detectors enabled in sleep");
   AST_LIMP_ENTRY: assert property (
      @(posedge i_clk) disable iff (i_rst)
      seq_limp_req |=> (mode_reg == CPMSL_MODE_LIMP))
      else $error("limp-home not entered");
   AST_SLEEP_ENTRY: assert property (
      @(posedge i_clk) disable iff (i_rst)
      seq_sleep_req |=> (mode_reg == CPMSL_MODE_SLEEP))
      else $error("sleep not entered");
   AST_REGS_HELD: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && regs_hold) |=> (map_a_reg == CPMSL_MAP_A_DEFAULT
                               && out_reg == CPMSL_OUT_DEFAULT))
      else $error("registers not at default");
   AST_VS_UV_OFF: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && vs_uv) |=> (drive_reg == '0))
      else $error("channel on under analog undervoltage");
   AST_VDD_NO_SERIAL: assert property (
      @(posedge i_clk) disable iff (i_rst)
      vdd_uv |-> !o_serial_enable)
      else $error("serial enabled under digital undervoltage");
   AST_NO_TURN_ON_LOW: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && vs_low) |=> ((drive_reg & ~$past(drive_reg)) == '0))
      else $error("channel turned on between thresholds");
   AST_MONITOR: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce |=> (mon_reg[0] == $past(in_a) && mon_reg[1] == $past(in_b)))
      else $error("input monitor wrong");

   // Channel composition and limp-home drive
   AST_DEFAULT_MAP_RST: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $fell(i_rst) |-> (map_a_reg == CPMSL_MAP_A_DEFAULT
                        && map_b_reg == CPMSL_MAP_B_DEFAULT))
      else $error("default input mapping missing after reset");
   AST_OUT_BITS_ON: assert property (
      @(posedge i_clk) disable iff (i_rst)
      seq_normal_full |=> ((drive_reg & $past(out_reg)) == $past(out_reg)))
      else $error("output register bit not driving its channel");
   AST_INPUT_A_MAP: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && mode_reg == CPMSL_MODE_NORMAL && !vs_low && in_a)
      |=> ((drive_reg & $past(map_a_reg)) == $past(map_a_reg)))
      else $error("input a mapping not applied");
   AST_LIMP_ONLY_DEFAULT: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && mode_reg == CPMSL_MODE_LIMP) |=> ((drive_reg
         & ~(CPMSL_MAP_A_DEFAULT | CPMSL_MAP_B_DEFAULT)) == '0))
      else $error("limp-home drive outside default mapping");
   AST_LIMP_DEFAULT_ON: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && mode_reg == CPMSL_MODE_LIMP && in_a && !vs_low)
      |=> ((drive_reg & CPMSL_MAP_A_DEFAULT) == CPMSL_MAP_A_DEFAULT))
      else $error("limp-home channel for input a not on");

   // Supply gating, serial output and limp-home monitor
   AST_BOTH_UV: assert property (
      @(posedge i_clk) disable iff (i_rst)
      seq_both_uv |=> (drive_reg == '0 && out_reg == CPMSL_OUT_DEFAULT))
      else $error("both supplies low but channels or registers live");
   AST_KEEP_ON: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && mode_reg == CPMSL_MODE_NORMAL && vs_low && !vs_uv)
      |=> ((drive_reg & $past(drive_reg) & $past(out_reg))
           == ($past(drive_reg) & $past(out_reg))))
      else $error("channel already on dropped between thresholds");
   AST_SO_RELEASED: assert property (
      @(posedge i_clk) disable iff (i_rst)
      pins_s[0] |-> o_so_oe_n)
      else $error("serial output driven while deselected");
   AST_LIMP_MONITOR: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && mode_reg == CPMSL_MODE_LIMP)
      |=> (mon_reg[0] == $past(in_a) && mon_reg[1] == $past(in_b)))
      else $error("input monitor stalled in limp-home");
   AST_VDD_REGS: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && vdd_uv) |=> (out_reg == CPMSL_OUT_DEFAULT
                            && map_b_reg == CPMSL_MAP_B_DEFAULT))
      else $error("registers kept under digital undervoltage");
   // Clock enable low must freeze every piece of state
   AST_CE_FREEZE: assert property (
      @(posedge i_clk) disable iff (i_rst)
      !i_ce |=> ($stable(drive_reg) && $stable(mode_reg)
                 && $stable(out_reg) && $stable(mon_reg)))
      else $error("state moved with clock enable low");
endmodule : cpmsl_ctrl
`default_nettype wire

// File: logic/cpmsl_pkg.sv
/*
 * Package for the direct-control and supply-mode logic: channel count,
 * default input mappings, reset values and hold-time figures.
 * Assumes a 20 MHz core clock.
 */
package cpmsl_pkg;
   localparam int          CPMSL_CHANNELS      = 8;
   localparam int          CPMSL_CLK_HZ        = 20_000_000;
   // Default mapping: input a drives channel 2, input b channel 3
   localparam logic [7:0]  CPMSL_MAP_A_DEFAULT = 8'h04;
   localparam logic [7:0]  CPMSL_MAP_B_DEFAULT = 8'h08;
   localparam logic [7:0]  CPMSL_OUT_DEFAULT   = 8'h00;
   localparam logic [7:0]  CPMSL_PWM_MAP_DEFAULT = 8'h00;
   // Mode-pin hold times in microseconds (values are plain defaults)
   localparam int          CPMSL_SLEEP_ENTRY_HOLD_US = 10;
   localparam int          CPMSL_SLEEP_EXIT_HOLD_US  = 10;
   localparam int          CPMSL_SLEEP_ENTRY_CYC =
      (CPMSL_SLEEP_ENTRY_HOLD_US * (CPMSL_CLK_HZ / 1_000_000));
   localparam int          CPMSL_SLEEP_EXIT_CYC =
      (CPMSL_SLEEP_EXIT_HOLD_US * (CPMSL_CLK_HZ / 1_000_000));

   typedef enum logic [1:0] {
      CPMSL_MODE_NORMAL = 2'b00,
      CPMSL_MODE_SLEEP  = 2'b01,
      CPMSL_MODE_LIMP   = 2'b10
   } cpmsl_mode_t;
endpackage : cpmsl_pkg

// File: logic/cpmsl_sync2.sv
/*
 * Two-flop synchroniser for a bus of pin levels.
 * Assumes the pins are asynchronous to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module cpmsl_sync2 #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic         i_ce,
   input  wire logic [W-1:0] i_async,
   input  wire logic [W-1:0] i_rst_val,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta_reg <= i_rst_val;
         sync_reg <= i_rst_val;
      end else if (i_ce) begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   // Both flops preload idle levels so no false mode follows reset
   assign o_sync = sync_reg;
endmodule : cpmsl_sync2
`default_nettype wire

// File: sim/cpmsl_host_model.sv
/*
 * Host-side model: drives the direct inputs and the sleep-request pin.
 * Assumes the bench posts wanted pin levels on i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module cpmsl_host_model
   import cpmsl_pkg::*;
#(
   parameter int HOLD = CPMSL_SLEEP_ENTRY_CYC
) (
   input  wire logic i_clk,
   input  wire logic i_sleep_want,
   input  wire logic i_in_a,
   input  wire logic i_in_b,
   output logic      o_sleep_req_n,
   output logic      o_direct_input_a,
   output logic      o_direct_input_b
);
   int hold_cnt = HOLD;
   initial o_sleep_req_n = 1'b1;
   // After its first move, pin only moves once the old level stood the full hold time
   always @(posedge i_clk) begin
      if (hold_cnt < HOLD) hold_cnt <= hold_cnt + 1;
      if (o_sleep_req_n == i_sleep_want && hold_cnt >= HOLD) begin
         o_sleep_req_n <= !i_sleep_want;
         hold_cnt      <= 0;
      end
   end
   assign o_direct_input_a = i_in_a;
   assign o_direct_input_b = i_in_b;
endmodule : cpmsl_host_model
`default_nettype wire

// File: sim/tb_cpmsl_ctrl.sv
/*
 * Bench for the control-pin and supply-mode logic.
 * Assumes the host model drives the pins, the bench the rest.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_cpmsl_ctrl
   import cpmsl_pkg::*;
;
   localparam int HOLD = CPMSL_SLEEP_ENTRY_CYC;
   logic       clk = 0, rst = 1, ce = 1, a = 0, b = 0, slp = 0, cs_n = 1;
   logic       so_d = 0, vdd_uv = 0, vs_uv = 0, below = 0, wr_en = 0;
   logic [1:0] pwm = 0, sel = 0, mon, mode;
   logic [7:0] wdat = 0, drv, mapa, mapb, outr;
   logic       sleep_n, pa, pb, ser_en, uv_en, so, so_oe_n;
   int         mismatches = 0, checked = 0, cyc = 0;

   initial begin
      forever #25 clk = ~clk;
   end

   cpmsl_host_model #(.HOLD(HOLD)) host_u (.i_clk(clk), .i_sleep_want(slp),
      .i_in_a(a), .i_in_b(b), .o_sleep_req_n(sleep_n),
      .o_direct_input_a(pa), .o_direct_input_b(pb));

   cpmsl_ctrl dut_u (.i_clk(clk), .i_rst(rst), .i_ce(ce),
      .i_direct_input_a(pa), .i_direct_input_b(pb), .i_sleep_req_n(sleep_n),
      .i_chip_select_n(cs_n), .i_spi_so_data(so_d), .i_vdd_uv(vdd_uv),
      .i_vs_uv(vs_uv), .i_vs_below_op(below), .i_pwm(pwm), .i_wr_en(wr_en),
      .i_wr_sel(sel), .i_wr_data(wdat), .o_channel_drive(drv),
      .o_input_level_monitor(mon), .o_input_a_channel_map(mapa),
      .o_input_b_channel_map(mapb), .o_out_reg(outr), .o_mode(mode),
      .o_serial_enable(ser_en), .o_uv_detect_enable(uv_en), .o_so_out(so),
      .o_so_oe_n(so_oe_n));

   // Ends off the edge so registered outputs have settled
   task automatic w(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : w

   task automatic wr(input logic [1:0] s, input logic [7:0] d);
      @(posedge clk) begin
         wr_en <= 1'b1;
         sel   <= s;
         wdat  <= d;
      end
      @(posedge clk) wr_en <= 1'b0;
   endtask : wr

   task automatic chk(input string nm, input logic [7:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wrap_up();
      if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         mismatches++;
         wrap_up();
      end
   end

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      w(4);
      chk("map_a", mapa, 8'h04);
      chk("map_b", mapb, 8'h08);
      chk("mode", 8'(mode), 8'(CPMSL_MODE_NORMAL));
      @(posedge clk) a <= 1'b1;
      w(6);
      chk("drive", drv, 8'h04);
      chk("monitor", mon, 8'h01);
      @(posedge clk) b <= 1'b1;
      w(6);
      chk("drive", drv, 8'h0C);
      chk("monitor", mon, 8'h03);
      wr(2'h1, 8'h01);
      wr(2'h2, 8'h80);
      wr(2'h0, 8'h10);
      wr(2'h3, 8'h20);
      @(posedge clk) pwm <= 2'b01;
      w(6);
      chk("map_a", mapa, 8'h01);
      chk("drive", drv, 8'hB1);
      @(posedge clk) begin
         pwm <= 2'b00;
         b   <= 1'b0;
         slp <= 1'b1;
      end
      // Limp-home: input a high while sleep requested
      w(HOLD + 10);
      chk("mode", 8'(mode), 8'(CPMSL_MODE_LIMP));
      chk("map_a", mapa, 8'h04);
      chk("out", outr, 8'h00);
      chk("drive", drv, 8'h04);
      @(posedge clk) b <= 1'b1;
      w(6);
      chk("monitor", mon, 8'h03);
      chk("drive", drv, 8'h0C);
      wr(2'h0, 8'hFF);
      w(2);
      chk("out", outr, 8'h00);
      @(posedge clk) begin
         a    <= 1'b0;
         b    <= 1'b0;
         cs_n <= 1'b0;
      end
      w(6);
      chk("mode", 8'(mode), 8'(CPMSL_MODE_SLEEP));
      chk("uv_det", 8'(uv_en), 8'h00);
      chk("so_oe_n", 8'(so_oe_n), 8'h01);
      chk("ser_en", 8'(ser_en), 8'h00);
      @(posedge clk) begin
         cs_n <= 1'b1;
         slp  <= 1'b0;
      end
      w(HOLD + 10);
      chk("mode", 8'(mode), 8'(CPMSL_MODE_NORMAL));
      // Selected in normal mode: serial output driven and registered
      @(posedge clk) begin
         so_d <= 1'b1;
         cs_n <= 1'b0;
      end
      w(6);
      chk("so_out", 8'(so), 8'h01);
      chk("so_oe_n", 8'(so_oe_n), 8'h00);
      @(posedge clk) cs_n <= 1'b1;
      wr(2'h0, 8'h03);
      @(posedge clk) below <= 1'b1;
      wr(2'h0, 8'h0F);
      w(6);
      chk("kept_on", drv & 8'h03, 8'h03);
      chk("no_turn_on", drv, 8'h03);
      @(posedge clk) begin
         below <= 1'b0;
         vs_uv <= 1'b1;
      end
      w(6);
      chk("drive", drv, 8'h00);
      @(posedge clk) vs_uv <= 1'b0;
      w(6);
      chk("drive", drv, 8'h0F);
      // Clock enable low: pin changes must not reach any state
      @(posedge clk) begin
         ce <= 1'b0;
         a  <= 1'b1;
      end
      w(6);
      chk("frozen_mon", mon, 8'h00);
      chk("frozen_drive", drv, 8'h0F);
      @(posedge clk) ce <= 1'b1;
      @(posedge clk) begin
         vdd_uv <= 1'b1;
         a      <= 1'b1;
      end
      w(6);
      chk("ser_en", 8'(ser_en), 8'h00);
      chk("out", outr, 8'h00);
      chk("drive", drv, 8'h04);
      @(posedge clk) vs_uv <= 1'b1;
      w(6);
      chk("drive", drv, 8'h00);
      chk("map_b", mapb, 8'h08);
      wrap_up();
   end
endmodule : tb_cpmsl_ctrl
`default_nettype wire
